// [design/dcs_control_source.sv]
// Drive control source logic: picks run, direction and speed source and decodes terminal inputs.
// Assumes terminals and keypad buttons are asynchronous pins; network commands are on i_clock.
// Functional notes
// - Source 0: terminals give all commands, analog input 1 gives speed.
// - Sources 1/2: keypad start/stop buttons, keypad or motor pot speed.
// - Keypad start behaviour may let digital input 1 start directly.
// - Source 3: terminals enable/disable, PI controller output gives speed.
// - Source 4: fieldbus module if fitted, else Modbus RTU.
// - Sources 4, 5, 6 run only while digital input 1 closed.
// - Source 5: follow master start/stop and scaled frequency.
// - Source 6: CANopen gives commands and speed.
// - Power-on autostart decides starting at power-up with enable present, except in keypad sources and edge-triggered run modes.
// - Keypad behaviour picks start speed and key-or-enable start.
// - Latched stop input stops whenever open.
// - Latched run starts when closed, runs only while closed.
// - Latched direction inputs pick forward or reverse by level.
// - Latched run fwd/rev runs that way while closed, stops when open.
// - Outside keypad mode, fieldbus starts ignored without hardware enable.
// - Normally open start rising edge starts if stop stays closed.
// - Paired start inputs active together start, stop held closed.
// - Normally closed stop falling edge stops the drive.
// - Edge start fwd/rev start in their direction, stop held closed.
//
// Design decisions made here: the APB interface to the registers and the address map.
`default_nettype none
module dcs_control_source
  import dcs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire dcs_term_s   i_term,
  input  wire logic        i_key_start,
  input  wire logic        i_key_stop,
  input  wire logic [15:0] i_ai1_speed,
  input  wire logic [15:0] i_kpd_speed,
  input  wire logic [15:0] i_pi_speed,
  input  wire logic        i_option_fitted,
  input  wire dcs_cmd_s    i_option_cmd,
  input  wire dcs_cmd_s    i_modbus_cmd,
  input  wire dcs_cmd_s    i_master_cmd,
  input  wire dcs_cmd_s    i_canopen_cmd,
  output logic             o_run,
  output logic             o_reverse,
  output logic      [15:0] o_speed_ref
);

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] flt_q;
  logic [NSYNC-1:0] flt_prev_q;
  assign raw_w = {i_key_stop, i_key_start, i_term.enable, i_term.di3, i_term.di2, i_term.di1};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      // Three stages; the filtered level moves only when stages two and three agree.
      always_ff @(posedge i_clock)
      begin
        if (!i_rst_n)
        begin
          s1_q[g]       <= 1'b0;
          s2_q[g]       <= 1'b0;
          s3_q[g]       <= 1'b0;
          flt_q[g]      <= 1'b0;
          flt_prev_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g]       <= raw_w[g];
          s2_q[g]       <= s1_q[g];
          s3_q[g]       <= s2_q[g];
          flt_prev_q[g] <= flt_q[g];
          if (s2_q[g] == s3_q[g])
          begin
            flt_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic di1;
  logic di2;
  logic di3;
  logic en;
  logic kstart_rise;
  logic kstop_rise;
  logic di1_rise;
  logic di1_fall;
  logic di3_rise;
  logic en_rise;
  assign di1         = flt_q[0];
  assign di2         = flt_q[1];
  assign di3         = flt_q[2];
  assign en          = flt_q[3];
  assign di1_rise    = flt_q[0] & ~flt_prev_q[0];
  assign di1_fall    = ~flt_q[0] & flt_prev_q[0];
  assign di3_rise    = flt_q[2] & ~flt_prev_q[2];
  assign en_rise     = flt_q[3] & ~flt_prev_q[3];
  assign kstart_rise = flt_q[4] & ~flt_prev_q[4];
  assign kstop_rise  = flt_q[5] & ~flt_prev_q[5];

  // ***************************************************
  // APB registers
  // ***************************************************
  logic [2:0]  source_q;
  logic [3:0]  termcfg_q;
  logic [2:0]  keypad_q;
  logic [15:0] follow_scale_q;
  logic        wr_w;
  logic        rd_w;
  logic        hit_w;
  assign wr_w  = i_psel & i_penable & i_pwrite;
  assign rd_w  = i_psel & ~i_penable & ~i_pwrite;
  assign hit_w = (i_paddr == DCS_OFS_SOURCE) | (i_paddr == DCS_OFS_TERMCFG) | (i_paddr == DCS_OFS_KEYPAD) |
                 (i_paddr == DCS_OFS_STATUS) | (i_paddr == DCS_OFS_SPEED);

  // Configuration writes take effect at the access edge.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      source_q       <= DCS_SOURCE_RST;
      termcfg_q      <= DCS_TERMCFG_RST;
      keypad_q       <= DCS_KEYPAD_RST;
      follow_scale_q <= DCS_SPEED_RST;
    end
    else if (wr_w)
    begin
      case (i_paddr)
        DCS_OFS_SOURCE:  source_q       <= i_pwdata[2:0];
        DCS_OFS_TERMCFG: termcfg_q      <= i_pwdata[3:0];
        DCS_OFS_KEYPAD:  keypad_q       <= i_pwdata[2:0];
        DCS_OFS_SPEED:   follow_scale_q <= i_pwdata[15:0];
        default:         ;
      endcase
    end
  end

  logic run_q;
  logic rev_q;
  logic [15:0] speed_q;
  logic powerup_q;

  // Read data is loaded in setup so it stands during access; one wait-free answer.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit_w;
      if (rd_w)
      begin
        case (i_paddr)
          DCS_OFS_SOURCE:  o_prdata <= {29'h0, source_q};
          DCS_OFS_TERMCFG: o_prdata <= {28'h0, termcfg_q};
          DCS_OFS_KEYPAD:  o_prdata <= {29'h0, keypad_q};
          DCS_OFS_STATUS:  o_prdata <= {19'h0, powerup_q, flt_q[5:0], en, rev_q, run_q, 3'h0};
          DCS_OFS_SPEED:   o_prdata <= {speed_q, follow_scale_q};
          default:         o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************
  // Command decode
  // ***************************************************
  dcs_source_e   src;
  dcs_run_mode_e rmode;
  dcs_kp_behav_e kbeh;
  logic          stop_latched;
  logic          pair_start;
  logic          autostart;
  assign src          = dcs_source_e'(source_q);
  assign rmode        = dcs_run_mode_e'(termcfg_q[DCS_TC_RUN_MODE_LO +: 2]);
  assign stop_latched = termcfg_q[DCS_TC_STOP_LATCHED];
  assign pair_start   = termcfg_q[DCS_TC_PAIR_START];
  assign kbeh         = dcs_kp_behav_e'(keypad_q[DCS_KP_BEHAV_LO +: 2]);
  assign autostart    = keypad_q[DCS_KP_AUTOSTART];

  logic     term_run_d;
  logic     term_rev_d;
  logic     kp_run_d;
  logic     net_run_d;
  logic     net_rev_d;
  logic     run_d;
  logic     rev_d;
  logic     stop_w;
  logic     start_w;
  dcs_cmd_s net_w;

  // Terminal decode: di1 is run (or stop, or run fwd), di2 direction (or run rev), di3 start.
  always_comb
  begin
    stop_w     = 1'b0;
    start_w    = 1'b0;
    term_run_d = run_q;
    term_rev_d = rev_q;
    case (rmode)
      DCS_RUN_LEVEL:
      begin
        term_run_d = di1;
        term_rev_d = di2;
      end
      DCS_RUN_FWDREV:
      begin
        term_run_d = di1 ^ di2;
        term_rev_d = di2 ? 1'b1 : (di1 ? 1'b0 : rev_q);
      end
      default:
      begin
        // Edge-triggered starts; stop is di1 held closed.
        stop_w  = stop_latched ? ~di1 : di1_fall;
        start_w = pair_start ? (di3 & di2 & (di3_rise | (flt_q[1] & ~flt_prev_q[1])))
                             : di3_rise;
        if (stop_w)
        begin
          term_run_d = 1'b0;
        end
        else if (start_w & di1)
        begin
          term_run_d = 1'b1;
          if (rmode == DCS_RUN_EDGE_DIR)
          begin
            term_rev_d = di2;
          end
        end
      end
    endcase
  end

  // Keypad mode: buttons, or di1/enable when the behaviour setting allows it.
  always_comb
  begin
    kp_run_d = run_q;
    if (kstop_rise)
    begin
      kp_run_d = 1'b0;
    end
    else if (kbeh == DCS_KP_DI1_ZERO || kbeh == DCS_KP_DI1_LAST)
    begin
      kp_run_d = di1 & en;
    end
    else if (kstart_rise & en)
    begin
      kp_run_d = 1'b1;
    end
    if (!en)
    begin
      kp_run_d = 1'b0;
    end
  end

  // Network sources, gated by enable and di1.
  always_comb
  begin
    case (src)
      DCS_SRC_FIELDBUS: net_w = i_option_fitted ? i_option_cmd : i_modbus_cmd;
      DCS_SRC_FOLLOWER: net_w = i_master_cmd;
      default:          net_w = i_canopen_cmd;
    endcase
    // A start is only taken with enable present; running stops if di1 opens.
    net_run_d = net_w.run & di1 & en & (run_q | ~powerup_q | autostart);
    net_rev_d = net_w.reverse;
  end

  // Final selection per control source.
  always_comb
  begin
    run_d = 1'b0;
    rev_d = rev_q;
    case (src)
      DCS_SRC_TERM, DCS_SRC_PI:
      begin
        run_d = term_run_d & en & (run_q | ~powerup_q | autostart | (rmode[1] == 1'b1));
        rev_d = term_rev_d;
      end
      DCS_SRC_KPD_UNI:
      begin
        run_d = kp_run_d;
        rev_d = 1'b0;
      end
      DCS_SRC_KPD_BI:
      begin
        run_d = kp_run_d;
        rev_d = (kstart_rise & run_q) ? ~rev_q : rev_q;
      end
      DCS_SRC_FIELDBUS, DCS_SRC_FOLLOWER, DCS_SRC_CANOPEN:
      begin
        run_d = net_run_d;
        rev_d = net_rev_d;
      end
      default:
      begin
        run_d = 1'b0;
      end
    endcase
  end

  logic [2:0] settle_q;

  // Settle count: the filters start at zero, so early levels and edges are not real pin events.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      settle_q <= 3'h0;
    end
    else if (settle_q != DCS_SETTLE_CYC)
    begin
      settle_q <= settle_q + 3'h1;
    end
  end

  // Power-up window: a terminal or network level start held since power-on needs autostart until it reopens.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      powerup_q <= 1'b1;
    end
    else if ((settle_q == DCS_SETTLE_CYC) &&
             (run_q || !en || en_rise || !(di1 || i_option_cmd.run || i_modbus_cmd.run)))
    begin
      powerup_q <= 1'b0;
    end
  end

  // Run and direction state.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      run_q <= 1'b0;
      rev_q <= 1'b0;
    end
    else
    begin
      run_q <= run_d;
      rev_q <= rev_d;
    end
  end

  logic [31:0] scaled_w;
  assign scaled_w = i_master_cmd.speed * follow_scale_q;

  // Speed reference per source; keypad may start from zero or last speed.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      speed_q <= DCS_SPEED_RST;
    end
    else
    begin
      case (src)
        DCS_SRC_TERM:      speed_q <= i_ai1_speed;
        DCS_SRC_PI:        speed_q <= i_pi_speed;
        DCS_SRC_KPD_UNI, DCS_SRC_KPD_BI:
          speed_q <= (!run_q && run_d && !kbeh[0]) ? 16'h0000 : i_kpd_speed;
        DCS_SRC_FOLLOWER:  speed_q <= scaled_w[27:12];
        DCS_SRC_FIELDBUS, DCS_SRC_CANOPEN: speed_q <= net_w.speed;
        default:           speed_q <= 16'h0000;
      endcase
    end
  end

  assign o_run       = run_q;
  assign o_reverse   = rev_q;
  assign o_speed_ref = speed_q;

endmodule // dcs_control_source
`default_nettype wire

// [design/dcs_pkg.sv]
// Package for the drive control source logic: register map, field layouts, enums, carriers.
// Assumes a 125 MHz single clock and an APB slave with 32-bit data.
`default_nettype none
package dcs_pkg;
  // ***************************************************
  // Register offsets (byte addresses)
  // ***************************************************
  localparam logic [7:0] DCS_OFS_SOURCE = 8'h00;
  localparam logic [7:0] DCS_OFS_TERMCFG = 8'h04;
  localparam logic [7:0] DCS_OFS_KEYPAD = 8'h08;
  localparam logic [7:0] DCS_OFS_STATUS = 8'h0C;
  localparam logic [7:0] DCS_OFS_SPEED = 8'h10;
  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int DCS_TC_STOP_LATCHED = 0;
  localparam int DCS_TC_RUN_MODE_LO = 1;
  localparam int DCS_TC_PAIR_START = 3;
  localparam int DCS_KP_AUTOSTART = 0;
  localparam int DCS_KP_BEHAV_LO = 1;
  localparam logic [2:0] DCS_SOURCE_RST = 3'h0;
  localparam logic [3:0] DCS_TERMCFG_RST = 4'h1;
  localparam logic [2:0] DCS_KEYPAD_RST = 3'h0;
  localparam logic [15:0] DCS_SPEED_RST = 16'h0000;
  // Cycles after reset before filtered pin levels and their edges can be trusted.
  localparam logic [2:0] DCS_SETTLE_CYC = 3'h7;
  // ***************************************************
  // Types
  // ***************************************************
  typedef enum logic [2:0] {
    DCS_SRC_TERM = 3'b000, DCS_SRC_KPD_UNI = 3'b001, DCS_SRC_KPD_BI = 3'b010, DCS_SRC_PI = 3'b011,
    DCS_SRC_FIELDBUS = 3'b100, DCS_SRC_FOLLOWER = 3'b101, DCS_SRC_CANOPEN = 3'b110, DCS_SRC_RSVD = 3'b111
  } dcs_source_e;
  // Run input wiring: latched level, latched run fwd/rev, edge-triggered start pulses.
  typedef enum logic [1:0] {
    DCS_RUN_LEVEL = 2'b00, DCS_RUN_FWDREV = 2'b01, DCS_RUN_EDGE = 2'b10, DCS_RUN_EDGE_DIR = 2'b11
  } dcs_run_mode_e;
  typedef enum logic [1:0] {
    DCS_KP_KEY_ZERO = 2'b00, DCS_KP_KEY_LAST = 2'b01, DCS_KP_DI1_ZERO = 2'b10, DCS_KP_DI1_LAST = 2'b11
  } dcs_kp_behav_e;
  // Terminal inputs: di1 stop/run/enable, di2 direction/run rev/second start, di3 start, plus enable.
  typedef struct packed {
    logic enable;
    logic di3;
    logic di2;
    logic di1;
  } dcs_term_s;
  // Command from a network-type source.
  typedef struct packed {
    logic        run;
    logic        reverse;
    logic [15:0] speed;
  } dcs_cmd_s;
endpackage : dcs_pkg
`default_nettype wire

// [tb/dcs_control_source_sva.sv]
// Checker for the control source block: bus answers, gating and speed selection.
// Assumes it is bound to the block and sees its ports only.
`default_nettype none
module dcs_control_source_sva
  import dcs_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire dcs_term_s   i_term,
  input wire logic [15:0] i_ai1_speed,
  input wire logic [15:0] i_pi_speed,
  input wire dcs_cmd_s    i_canopen_cmd,
  input wire logic        o_run,
  input wire logic [15:0] o_speed_ref
);
  logic [2:0] src_q;
  logic [3:0] en_lo_q;
  logic [3:0] di1_lo_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ********************
  // Helper state
  // ********************
  // Shadow of the source selector, so speed checks know the source.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      src_q <= DCS_SOURCE_RST;
    else if (i_psel && i_penable && i_pwrite && i_paddr == DCS_OFS_SOURCE)
      src_q <= i_pwdata[2:0];
  end
  // Saturating counts of cycles that enable and input 1 stayed open.
  always_ff @(posedge i_clock)
  begin
    en_lo_q  <= (!i_rst_n || i_term.enable) ? 4'h0 : en_lo_q + {3'h0, en_lo_q != 4'hF};
    di1_lo_q <= (!i_rst_n || i_term.di1) ? 4'h0 : di1_lo_q + {3'h0, di1_lo_q != 4'hF};
  end
  // ********************
  // Assertions
  // ********************
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (o_pready && i_paddr > 8'h10 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (o_pready && i_paddr <= 8'h10 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("mapped access refused");
  a_enable_gate: assert property (en_lo_q >= 4'h8 |-> !o_run)
    else $error("run without enable");
  a_net_di1: assert property ((src_q inside {3'h4, 3'h5, 3'h6} && di1_lo_q >= 4'h8) [*3] |-> !o_run)
    else $error("network run with input 1 open");
  a_term_speed: assert property ((src_q == 3'h0 && o_run && $stable(i_ai1_speed)) [*3] |-> o_speed_ref == i_ai1_speed)
    else $error("terminal speed not analog 1");
  a_pi_speed: assert property ((src_q == 3'h3 && o_run && $stable(i_pi_speed)) [*3] |-> o_speed_ref == i_pi_speed)
    else $error("speed not from PI");
  a_can_speed: assert property ((src_q == 3'h6 && $stable(i_canopen_cmd)) [*3] |-> o_speed_ref == i_canopen_cmd.speed)
    else $error("speed not from CANopen");
endmodule // dcs_control_source_sva
bind dcs_control_source dcs_control_source_sva dcs_control_source_sva_i (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_term(i_term), .i_ai1_speed(i_ai1_speed), .i_pi_speed(i_pi_speed), .i_canopen_cmd(i_canopen_cmd),
  .o_run(o_run), .o_speed_ref(o_speed_ref));
`default_nettype wire

// [tb/dcs_net_masters.sv]
// Network masters at the far side: option module, Modbus RTU, master drive, CANopen.
// Assumes the bench picks the master that talks; the idle ones babble.
`default_nettype none
module dcs_net_masters
  import dcs_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_sel,
  input  wire dcs_cmd_s   i_cmd,
  output var dcs_cmd_s    o_option_cmd,
  output var dcs_cmd_s    o_modbus_cmd,
  output var dcs_cmd_s    o_master_cmd,
  output var dcs_cmd_s    o_canopen_cmd
);
  logic [17:0] noise_q;
  // ********************
  // Command delivery
  // ********************
  // Idle masters send a pattern that changes each cycle, so a wrong pick shows.
  always_ff @(posedge i_clock)
  begin
    noise_q       <= i_rst_n ? noise_q + 18'h2AAAB : 18'h15555;
    o_option_cmd  <= (i_sel == 2'h0) ? i_cmd : dcs_cmd_s'(noise_q);
    o_modbus_cmd  <= (i_sel == 2'h1) ? i_cmd : dcs_cmd_s'(~noise_q);
    o_master_cmd  <= (i_sel == 2'h2) ? i_cmd : dcs_cmd_s'(noise_q);
    o_canopen_cmd <= (i_sel == 2'h3) ? i_cmd : dcs_cmd_s'(~noise_q);
  end
endmodule // dcs_net_masters
`default_nettype wire

// [tb/tb_dcs_control_source.sv]
// Testbench for the control source block: pins, APB registers and network masters.
// Assumes the master model and the checker are compiled first.
`default_nettype none
module tb_dcs_control_source import dcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, key_start, key_stop, fitted, pready, pslverr, run, rev, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] ai1, kpd, pi, spd;
  logic [1:0]  sel;
  dcs_term_s   term;
  dcs_cmd_s    cmd, opt_c, mb_c, mst_c, can_c;
  int          failures, check_count;
  logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
  int          rstv [5] = '{DCS_SOURCE_RST, DCS_TERMCFG_RST, DCS_KEYPAD_RST, DCS_SPEED_RST, 0};
  dcs_control_source dcs_control_source_i (
    .i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_term(term), .i_key_start(key_start), .i_key_stop(key_stop), .i_ai1_speed(ai1),
    .i_kpd_speed(kpd), .i_pi_speed(pi), .i_option_fitted(fitted), .i_option_cmd(opt_c),
    .i_modbus_cmd(mb_c), .i_master_cmd(mst_c), .i_canopen_cmd(can_c), .o_run(run),
    .o_reverse(rev), .o_speed_ref(spd));
  dcs_net_masters dcs_net_masters_i (.i_clock(clk), .i_rst_n(rst_n), .i_sel(sel), .i_cmd(cmd),
    .o_option_cmd(opt_c), .o_modbus_cmd(mb_c), .o_master_cmd(mst_c), .o_canopen_cmd(can_c));
  // ********************
  // Clock, tasks, tests
  // ********************
  // Free running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input int e, input logic [31:0] g);
    check_count++;
    if (g !== 32'(e))
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && n++ < 16);
    chk("pready", 1, {31'h0, pready});
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Lets the pin filters settle, then compares outputs with the model; -1 means any reverse or speed.
  task automatic st(input int m_run, input int m_rev, input int m_spd);
    repeat (10) @(posedge clk);
    chk("run", m_run, {31'h0, run});
    if (m_rev >= 0) chk("reverse", m_rev, {31'h0, rev});
    if (m_spd >= 0) chk("speed", m_spd, {16'h0, spd});
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    repeat (4000) @(posedge clk);
    failures++;
    results();
  end
  // Main sequence; run input is held closed through reset.
  initial
  begin
    failures = 0;
    check_count = 0;
    rv = $urandom(32'hD78142CA);
    {psel, penable, pwrite, key_start, key_stop, fitted, rst_n, paddr, pwdata, sel, cmd} = '0;
    term = 4'b1001;
    ai1 = 16'($urandom);
    kpd = 16'($urandom);
    pi = 16'($urandom);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i])
    begin
      apb(0, ofs[i], 0);
      // The speed word also shows the live terminal speed in its upper half.
      chk("register", (i == 3) ? int'({ai1, 16'h0000}) : rstv[i], rv);
    end
    chk("pslverr", 1, {31'h0, err});
    st(0, -1, -1);
    term <= 4'b1000;
    st(0, -1, -1);
    term <= 4'b1001;
    st(1, 0, ai1);
    term <= 4'b1011;
    st(1, 1, ai1);
    term <= 4'b1010;
    st(0, -1, -1);
    apb(1, DCS_OFS_TERMCFG, 32'h3);
    st(1, 1, -1);
    term <= 4'b1000;
    st(0, -1, -1);
    apb(1, DCS_OFS_TERMCFG, 32'h1);
    apb(1, DCS_OFS_SOURCE, 32'h3);
    term <= 4'b1001;
    st(1, 0, pi);
    term <= 4'b1000;
    apb(1, DCS_OFS_SOURCE, 32'h0);
    apb(1, DCS_OFS_TERMCFG, 32'h4);
    term <= 4'b1100;
    st(0, -1, -1);
    term <= 4'b1001;
    st(0, -1, -1);
    term <= 4'b1101;
    st(1, 0, ai1);
    term <= 4'b1001;
    st(1, 0, -1);
    term <= 4'b1000;
    st(0, -1, -1);
    term <= 4'b1001;
    apb(1, DCS_OFS_TERMCFG, 32'hC);
    term <= 4'b1111;
    st(1, -1, -1);
    term <= 4'b1000;
    apb(1, DCS_OFS_TERMCFG, 32'h6);
    term <= 4'b1011;
    st(0, -1, -1);
    term <= 4'b1111;
    st(1, 1, -1);
    term <= 4'b1000;
    apb(1, DCS_OFS_SOURCE, 32'h1);
    apb(1, DCS_OFS_KEYPAD, 32'h2);
    key_start <= 1'b1;
    st(1, -1, kpd);
    key_start <= 1'b0;
    key_stop <= 1'b1;
    st(0, -1, -1);
    key_stop <= 1'b0;
    apb(1, DCS_OFS_KEYPAD, 32'h6);
    term <= 4'b1001;
    st(1, -1, kpd);
    term <= 4'b0000;
    apb(1, DCS_OFS_SPEED, 32'h800);
    term <= 4'b1001;
    for (int k = 0; k < 4; k++)
    begin
      apb(1, DCS_OFS_SOURCE, (k < 2) ? 32'h4 : 32'(k + 3));
      fitted <= (k == 0);
      sel <= 2'(k);
      cmd <= {1'b1, 1'($urandom), 16'($urandom)};
      @(posedge clk);
      st(1, cmd.reverse, (k == 2) ? cmd.speed / 2 : cmd.speed);
    end
    term <= 4'b1000;
    st(0, -1, -1);
    term <= 4'b0001;
    st(0, -1, -1);
    results();
  end
endmodule // tb_dcs_control_source
`default_nettype wire
